// ===== common/jbs_map.svh
`ifndef JBS_MAP_SVH
`define JBS_MAP_SVH

// ----------------------------------------
// Scan path dimensions
// ----------------------------------------
`define JBS_IR_W 3
`define JBS_IR_CAPTURE 3'h1
`define JBS_NPAD 8
`define JBS_BSR_LEN 24
`define JBS_CELLS_PER_PAD 3

// ----------------------------------------
// Cell position inside each pad group
// ----------------------------------------
`define JBS_CELL_IN 0
`define JBS_CELL_OUT 1
`define JBS_CELL_OE 2

`endif

// ===== common/jbs_pkg.sv
package jbs_pkg;

	// ----------------------------------------
	// Controller states, one-hot
	// ----------------------------------------
	typedef enum logic [15:0] {
		JBS_TLR = 16'h0001,
		JBS_RTI = 16'h0002,
		JBS_SEL_DR = 16'h0004,
		JBS_CAP_DR = 16'h0008,
		JBS_SH_DR = 16'h0010,
		JBS_EX1_DR = 16'h0020,
		JBS_PA_DR = 16'h0040,
		JBS_EX2_DR = 16'h0080,
		JBS_UP_DR = 16'h0100,
		JBS_SEL_IR = 16'h0200,
		JBS_CAP_IR = 16'h0400,
		JBS_SH_IR = 16'h0800,
		JBS_EX1_IR = 16'h1000,
		JBS_PA_IR = 16'h2000,
		JBS_EX2_IR = 16'h4000,
		JBS_UP_IR = 16'h8000
	} jbs_tap_t;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		JBS_EXTEST = 3'h0,
		JBS_SAMPLE = 3'h1,
		JBS_TRISTATE = 3'h5,
		JBS_CONTIN = 3'h6,
		JBS_BYPASS = 3'h7
	} jbs_instr_t;

endpackage : jbs_pkg

// ===== core/jbs_bsr.sv
`include "jbs_map.svh"

// Boundary-scan chain: shift stages plus update latches
module jbs_bsr (
	input wire logic clock_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic capture_i, // Load parallel inputs
	input wire logic shift_i, // Shift one place
	input wire logic update_i, // Copy chain to latches
	input wire logic sdi_i, // Serial in
	input wire logic [`JBS_BSR_LEN-1:0] cap_data_i, // Parallel capture
	output logic [`JBS_BSR_LEN-1:0] upd_data_o, // Update latches
	output logic sdo_o // Serial out
);

	// ----------------------------------------
	// Cells
	// ----------------------------------------
	logic [`JBS_BSR_LEN-1:0] chain_reg; // Shift stages
	logic [`JBS_BSR_LEN:0] link; // Serial links, top fed by sdi

	assign link[`JBS_BSR_LEN] = sdi_i;
	assign sdo_o = chain_reg[0];

	genvar g;
	generate
		for (g = 0; g < `JBS_BSR_LEN; g++) begin : g_cell
			assign link[g] = chain_reg[g];
			// Each cell captures or takes its upstream neighbour
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					chain_reg[g] <= 1'b0;
				end else if (capture_i) begin
					chain_reg[g] <= cap_data_i[g];
				end else if (shift_i) begin
					chain_reg[g] <= link[g+1];
				end
			end
			// Latches hold steady while the chain shifts, so pads never ripple
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					upd_data_o[g] <= 1'b0;
				end else if (update_i) begin
					upd_data_o[g] <= chain_reg[g];
				end
			end
		end
	endgenerate

endmodule : jbs_bsr

// ===== core/jbs_test_logic.sv
// Behaviour
// - Four serial pins: clock, data in, out, mode
// - Instruction, bypass and boundary-scan registers
// - Three-bit shift instruction register, decoded
// - Instruction selects serial data register
// - Code 000 drives boundary data onto pads
// - Code 001 samples live pins, allows preload
// - Code 101 floats all pads
// - Code 110 enters continuity test mode
// - Code 111 puts bypass bit in path
// - Bypass leaves functional logic untouched
// - Power-up loads bypass instruction automatically
// - Bypass register is one shift stage
// - Full standard controller on mode select
// - Set enable cell makes data cell drive
`include "jbs_map.svh"

module jbs_test_logic (
	input wire logic clock_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, high
	input wire logic tck_i, // Test clock pin
	input wire logic tms_i, // Test mode select pin
	input wire logic tdi_i, // Test data in pin
	output logic tdo_o, // Test data out value
	output logic tdo_oe_o, // Test data out enable
	input wire logic [`JBS_NPAD-1:0] func_out_i, // Core pad data
	input wire logic [`JBS_NPAD-1:0] func_oe_i, // Core pad enables
	input wire logic [`JBS_NPAD-1:0] pad_in_i, // Pad input levels
	output logic [`JBS_NPAD-1:0] pad_out_o, // Pad drive value
	output logic [`JBS_NPAD-1:0] pad_oe_o, // Pad drive enable
	output logic [`JBS_NPAD-1:0] core_in_o, // Pad levels to core
	output logic [`JBS_IR_W-1:0] instr_o // Active instruction
);
	import jbs_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic tck_s1_reg, tck_s2_reg, tck_d_reg; // Clock sync and delay
	logic tms_s1_reg, tms_s2_reg; // Mode select sync
	logic tdi_s1_reg, tdi_s2_reg; // Data in sync
	logic [`JBS_NPAD-1:0] pad_s1_reg, pad_s2_reg; // Pad input sync
	logic tck_rise, tck_fall; // Edge strobes

	// Two stages on every pin; only the second stage, and for the test clock its delayed copy, is looked at
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tck_s1_reg <= 1'b0;
			tck_s2_reg <= 1'b0;
			tck_d_reg <= 1'b0;
			tms_s1_reg <= 1'b1;
			tms_s2_reg <= 1'b1;
			tdi_s1_reg <= 1'b1;
			tdi_s2_reg <= 1'b1;
			pad_s1_reg <= '0;
			pad_s2_reg <= '0;
		end else begin
			tck_s1_reg <= tck_i;
			tck_s2_reg <= tck_s1_reg;
			tck_d_reg <= tck_s2_reg;
			tms_s1_reg <= tms_i;
			tms_s2_reg <= tms_s1_reg;
			tdi_s1_reg <= tdi_i;
			tdi_s2_reg <= tdi_s1_reg;
			pad_s1_reg <= pad_in_i;
			pad_s2_reg <= pad_s1_reg;
		end
	end

	// Test clock edges as one-cycle enables
	assign tck_rise = tck_s2_reg & ~tck_d_reg;
	assign tck_fall = ~tck_s2_reg & tck_d_reg;

	// ----------------------------------------
	// Controller state machine
	// ----------------------------------------
	jbs_tap_t tap_reg, tap_next; // Controller state

	// Standard sixteen-state walk, steered by mode select
	always_comb begin
		tap_next = tap_reg;
		case (tap_reg)
			JBS_TLR: tap_next = tms_s2_reg ? JBS_TLR : JBS_RTI;
			JBS_RTI: tap_next = tms_s2_reg ? JBS_SEL_DR : JBS_RTI;
			JBS_SEL_DR: tap_next = tms_s2_reg ? JBS_SEL_IR : JBS_CAP_DR;
			JBS_CAP_DR: tap_next = tms_s2_reg ? JBS_EX1_DR : JBS_SH_DR;
			JBS_SH_DR: tap_next = tms_s2_reg ? JBS_EX1_DR : JBS_SH_DR;
			JBS_EX1_DR: tap_next = tms_s2_reg ? JBS_UP_DR : JBS_PA_DR;
			JBS_PA_DR: tap_next = tms_s2_reg ? JBS_EX2_DR : JBS_PA_DR;
			JBS_EX2_DR: tap_next = tms_s2_reg ? JBS_UP_DR : JBS_SH_DR;
			JBS_UP_DR: tap_next = tms_s2_reg ? JBS_SEL_DR : JBS_RTI;
			JBS_SEL_IR: tap_next = tms_s2_reg ? JBS_TLR : JBS_CAP_IR;
			JBS_CAP_IR: tap_next = tms_s2_reg ? JBS_EX1_IR : JBS_SH_IR;
			JBS_SH_IR: tap_next = tms_s2_reg ? JBS_EX1_IR : JBS_SH_IR;
			JBS_EX1_IR: tap_next = tms_s2_reg ? JBS_UP_IR : JBS_PA_IR;
			JBS_PA_IR: tap_next = tms_s2_reg ? JBS_EX2_IR : JBS_PA_IR;
			JBS_EX2_IR: tap_next = tms_s2_reg ? JBS_UP_IR : JBS_SH_IR;
			JBS_UP_IR: tap_next = tms_s2_reg ? JBS_SEL_DR : JBS_RTI;
			default: tap_next = JBS_TLR; // Illegal code recovers to reset
		endcase
	end

	// State advances only on a rising test clock edge
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tap_reg <= JBS_TLR;
		end else if (tck_rise) begin
			tap_reg <= tap_next;
		end
	end

	// Register controls derived from the state
	logic cap_dr, sh_dr, up_dr; // Data register strobes
	assign cap_dr = tck_rise && (tap_reg == JBS_CAP_DR);
	assign sh_dr = tck_rise && (tap_reg == JBS_SH_DR);
	// Update happens on the falling edge, half a test clock after entry
	assign up_dr = tck_fall && (tap_reg == JBS_UP_DR);

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	logic [`JBS_IR_W-1:0] ir_shift_reg; // Instruction shift stage
	logic [`JBS_IR_W-1:0] ir_reg; // Held instruction code
	jbs_instr_t instr; // Decoded instruction

	// Reserved codes collapse to bypass so no undefined mode exists
	function automatic jbs_instr_t jbs_decode(input logic [`JBS_IR_W-1:0] code);
		case (code)
			JBS_EXTEST: jbs_decode = JBS_EXTEST;
			JBS_SAMPLE: jbs_decode = JBS_SAMPLE;
			JBS_TRISTATE: jbs_decode = JBS_TRISTATE;
			JBS_CONTIN: jbs_decode = JBS_CONTIN;
			default: jbs_decode = JBS_BYPASS;
		endcase
	endfunction : jbs_decode

	assign instr = jbs_decode(ir_reg);

	// Shift stage: fixed capture pattern, then shifts toward the out pin
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ir_shift_reg <= `JBS_IR_CAPTURE;
		end else if (tck_rise && tap_reg == JBS_CAP_IR) begin
			ir_shift_reg <= `JBS_IR_CAPTURE;
		end else if (tck_rise && tap_reg == JBS_SH_IR) begin
			ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[`JBS_IR_W-1:1]};
		end
	end

	// Held code changes only at update or in test-logic reset, so a scan never disturbs the mode
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ir_reg <= JBS_BYPASS;
		end else if (tap_reg == JBS_TLR) begin
			ir_reg <= JBS_BYPASS;
		end else if (tck_fall && tap_reg == JBS_UP_IR) begin
			ir_reg <= ir_shift_reg;
		end
	end

	// ----------------------------------------
	// Bypass and boundary-scan registers
	// ----------------------------------------
	logic byp_reg; // Single bypass stage
	logic bsr_sel; // Boundary chain in path
	logic bsr_sdo; // Boundary chain serial out
	logic [`JBS_BSR_LEN-1:0] bsr_cap; // Parallel capture data
	logic [`JBS_BSR_LEN-1:0] bsr_upd; // Update latch outputs
	logic [`JBS_NPAD-1:0] bsr_out_bits, bsr_oe_bits; // Latched pad drive

	// Chain sits in the path for external test and sample only; continuity uses bypass
	assign bsr_sel = (instr == JBS_EXTEST) || (instr == JBS_SAMPLE);

	// One stage that captures zero, as the standard asks
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			byp_reg <= 1'b0;
		end else if (cap_dr && !bsr_sel) begin
			byp_reg <= 1'b0;
		end else if (sh_dr && !bsr_sel) begin
			byp_reg <= tdi_s2_reg;
		end
	end

	// Gather cells: pad input level, core data, core enable
	genvar p;
	generate
		for (p = 0; p < `JBS_NPAD; p++) begin : g_pad
			assign bsr_cap[`JBS_CELLS_PER_PAD*p+`JBS_CELL_IN] = pad_s2_reg[p];
			assign bsr_cap[`JBS_CELLS_PER_PAD*p+`JBS_CELL_OUT] = func_out_i[p];
			assign bsr_cap[`JBS_CELLS_PER_PAD*p+`JBS_CELL_OE] = func_oe_i[p];
			assign bsr_out_bits[p] = bsr_upd[`JBS_CELLS_PER_PAD*p+`JBS_CELL_OUT];
			assign bsr_oe_bits[p] = bsr_upd[`JBS_CELLS_PER_PAD*p+`JBS_CELL_OE];
		end
	endgenerate

	// Chain also shifts under sample, which is how preload works
	jbs_bsr u_bsr (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.capture_i(cap_dr && bsr_sel),
		.shift_i(sh_dr && bsr_sel),
		.update_i(up_dr && bsr_sel),
		.sdi_i(tdi_s2_reg),
		.cap_data_i(bsr_cap),
		.upd_data_o(bsr_upd),
		.sdo_o(bsr_sdo)
	);

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	// Out pin changes on the falling edge so the far end samples it stable
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_o <= (tap_reg == JBS_SH_DR) || (tap_reg == JBS_SH_IR);
			if (tap_reg == JBS_SH_IR) begin
				tdo_o <= ir_shift_reg[0];
			end else if (bsr_sel) begin
				tdo_o <= bsr_sdo;
			end else begin
				tdo_o <= byp_reg;
			end
		end
	end

	// ----------------------------------------
	// Pad control
	// ----------------------------------------
	// One register stage keeps every pad output glitch free
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pad_out_o <= '0;
			pad_oe_o <= '0;
		end else begin
			case (instr)
				JBS_EXTEST: begin
					pad_out_o <= bsr_out_bits;
					pad_oe_o <= bsr_oe_bits;
				end
				JBS_TRISTATE: begin
					pad_out_o <= func_out_i;
					pad_oe_o <= '0;
				end
				JBS_CONTIN: begin
					// Every pad driven from the latches for a quick wiring check
					pad_out_o <= bsr_out_bits;
					pad_oe_o <= '1;
				end
				default: begin
					pad_out_o <= func_out_i;
					pad_oe_o <= func_oe_i;
				end
			endcase
		end
	end

	// Core always sees the real pad levels; the test logic never blocks them
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			core_in_o <= '0;
			instr_o <= JBS_BYPASS;
		end else begin
			core_in_o <= pad_s2_reg;
			instr_o <= instr;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_bypass: assert property (@(posedge clock_i)
		rst_i |=> (ir_reg == JBS_BYPASS) && (tap_reg == JBS_TLR))
		else $error("reset did not load bypass");

	a_tms_to_reset: assert property (@(posedge clock_i) disable iff (rst_i)
		(tck_rise && tms_s2_reg && tap_reg == JBS_SEL_IR) |=> (tap_reg == JBS_TLR))
		else $error("select-IR with tms high missed reset");

	a_ir_capture: assert property (@(posedge clock_i) disable iff (rst_i)
		(tck_rise && tap_reg == JBS_CAP_IR) |=> (ir_shift_reg == `JBS_IR_CAPTURE))
		else $error("instruction capture pattern wrong");

	a_ir_update: assert property (@(posedge clock_i) disable iff (rst_i)
		(tck_fall && tap_reg == JBS_UP_IR) |=> (ir_reg == $past(ir_shift_reg)))
		else $error("instruction not updated");

	a_reserved_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
		(ir_reg inside {3'h2, 3'h3, 3'h4}) |=> (instr_o == JBS_BYPASS) && (pad_oe_o == $past(func_oe_i)))
		else $error("reserved code not bypass");

	a_bypass_shift: assert property (@(posedge clock_i) disable iff (rst_i)
		(sh_dr && instr == JBS_BYPASS) |=> (byp_reg == $past(tdi_s2_reg)))
		else $error("bypass stage did not shift");

	a_extest_drive: assert property (@(posedge clock_i) disable iff (rst_i)
		(instr == JBS_EXTEST) |=> (pad_out_o == $past(bsr_out_bits)) && (pad_oe_o == $past(bsr_oe_bits)))
		else $error("extest pads not from latches");

	a_tristate_float: assert property (@(posedge clock_i) disable iff (rst_i)
		(instr == JBS_TRISTATE) |=> (pad_oe_o == '0))
		else $error("pads driven in tristate");

	a_bypass_func: assert property (@(posedge clock_i) disable iff (rst_i)
		(instr == JBS_BYPASS) |=> (pad_out_o == $past(func_out_i)) && (pad_oe_o == $past(func_oe_i)))
		else $error("bypass altered functional pads");

	a_tdo_idle: assert property (@(posedge clock_i) disable iff (rst_i)
		(tck_fall && tap_reg != JBS_SH_DR && tap_reg != JBS_SH_IR) |=> !tdo_oe_o)
		else $error("data out driven outside shift");

endmodule : jbs_test_logic

// ===== dv/jbs_tap_master.sv
// Board-side scan controller: paces the test clock from the system clock
module jbs_tap_master (
	input wire logic clock_i, // System clock used for pacing
	output logic tck_o, // Test clock, still between scans
	output logic tms_o, // Mode select
	output logic tdi_o, // Data towards the device
	input wire logic tdo_i, // Data from the device
	input wire logic tdo_oe_i // Device drives its data out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// One 160 ns test clock period; tdo is taken just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		repeat (8) @(posedge clock_i);
		#1;
		tdo = tdo_oe_i ? tdo_i : 1'bx; // An undriven line never counts as a bit
		tck_o = 1'b1;
		repeat (8) @(posedge clock_i);
		#1;
		tck_o = 1'b0;
	endtask : step

	// Move the controller; data in flips so stale levels are never reused
	task automatic walk(input logic tms);
		logic d;
		step(tms, ~tdi_o, d);
	endtask : walk

	// Five high mode bits reach reset from anywhere, then idle
	task automatic tap_reset();
		repeat (5) walk(1'b1);
		walk(1'b0);
	endtask : tap_reset

	// Instruction load from idle, returning the captured bits
	task automatic scan_ir(input logic [2:0] v, output logic [2:0] cap);
		logic b;
		walk(1'b1);
		walk(1'b1);
		walk(1'b0);
		walk(1'b0);
		for (int i = 0; i < 3; i++) begin
			step(i == 2, v[i], b);
			cap[i] = b;
		end
		// Pass through update before any data scan
		walk(1'b1);
		walk(1'b0);
	endtask : scan_ir

	// Data scan of n bits from idle, first bit in and out is bit 0
	task automatic scan_dr(input logic [23:0] din, input int n, output logic [23:0] dout);
		logic b;
		dout = 24'h00_0000;
		walk(1'b1);
		walk(1'b0);
		walk(1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
		// Update before returning to idle
		walk(1'b1);
		walk(1'b0);
	endtask : scan_dr
endmodule : jbs_tap_master

// ===== dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import jbs_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock_i = 1'b0; // System clock
	logic rst_i = 1'b1; // Synchronous reset
	logic tck, tms, tdi, tdo, tdo_oe; // Test link
	logic [7:0] func_out = 8'hC3; // Core pad data
	logic [7:0] func_oe = 8'h96; // Core pad enables
	logic [7:0] pad_in = 8'h5A; // Pad levels
	logic [7:0] pad_out, pad_oe, core_in; // Pad side results
	logic [2:0] instr; // Active instruction
	int num_errors = 0; // Mismatches
	int cmp_count = 0; // Comparisons

	jbs_test_logic i_dut (.clock_i(clock_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .func_out_i(func_out), .func_oe_i(func_oe), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe), .core_in_o(core_in), .instr_o(instr));

	jbs_tap_master i_master (.clock_i(clock_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
		.tdo_oe_i(tdo_oe));

	initial begin
		forever #5 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Pads follow the core when no test drives them
	task automatic chk_pass();
		check("pad_out pass", 24'(func_out), 24'(pad_out));
		check("pad_oe pass", 24'(func_oe), 24'(pad_oe));
	endtask : chk_pass

	// Chain image with data and enable cells set, input cells clear
	function automatic logic [23:0] mk_bsr(input logic [7:0] o, input logic [7:0] oe);
		logic [23:0] r;
		r = 24'h00_0000;
		for (int k = 0; k < 8; k++) begin
			r[3*k+1] = o[k];
			r[3*k+2] = oe[k];
		end
		return r;
	endfunction : mk_bsr

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		check("instr after reset", 24'h00_0007, 24'(instr));
		check("tdo_oe idle", 24'h00_0000, 24'(tdo_oe));
		chk_pass();
		i_master.tap_reset();
		$display("test_reset done");
	endtask : test_reset

	// Preload under sample, then external test drives the preloaded cells
	task automatic test_preload();
		logic [2:0] cap;
		logic [23:0] d;
		logic [7:0] seen_in;
		i_master.scan_ir(3'h1, cap);
		check("ir capture", 24'h00_0001, 24'(cap));
		check("instr sample", 24'h00_0001, 24'(instr));
		chk_pass();
		i_master.scan_dr(mk_bsr(8'hA5, 8'h3C), 24, d);
		for (int k = 0; k < 8; k++)
			seen_in[k] = d[3*k];
		check("sampled inputs", 24'(pad_in), 24'(seen_in));
		check("sampled core cells", mk_bsr(func_out, func_oe), d & mk_bsr(8'hFF, 8'hFF));
		i_master.scan_ir(3'h0, cap);
		check("instr extest", 24'h00_0000, 24'(instr));
		check("extest out", 24'h00_00A5, 24'(pad_out));
		check("extest oe", 24'h00_003C, 24'(pad_oe));
		$display("test_preload done");
	endtask : test_preload

	// Every other code: decode, pad effect and, except for tristate, serial path
	task automatic test_modes();
		logic [2:0] codes[6] = '{3'h5, 3'h6, 3'h7, 3'h2, 3'h3, 3'h4};
		logic [2:0] cap;
		logic [23:0] d;
		foreach (codes[i]) begin
			i_master.scan_ir(codes[i], cap);
			check("instr", (codes[i] inside {3'h2, 3'h3, 3'h4}) ? 24'h00_0007 : 24'(codes[i]), 24'(instr));
			if (codes[i] == 3'h5) begin
				check("tristate oe", 24'h00_0000, 24'(pad_oe));
			end else begin
				i_master.scan_dr(24'h00_000B, 4, d);
				check("one bit path", 24'h00_0006, d);
				if (codes[i] == 3'h6) begin
					check("contin oe", 24'h00_00FF, 24'(pad_oe));
					check("contin out", 24'h00_00A5, 24'(pad_out));
				end else begin
					chk_pass();
					check("core_in bypass", 24'(pad_in), 24'(core_in));
				end
			end
		end
		$display("test_modes done");
	endtask : test_modes

	// Controller reset restores bypass from external test
	task automatic test_tlr();
		logic [2:0] cap;
		i_master.scan_ir(3'h0, cap);
		check("extest again", 24'h00_0000, 24'(instr));
		pad_in = 8'hA3;
		repeat (6) @(posedge clock_i);
		#1;
		check("core_in extest", 24'h00_00A3, 24'(core_in));
		i_master.tap_reset();
		check("instr after tlr", 24'h00_0007, 24'(instr));
		chk_pass();
		$display("test_tlr done");
	endtask : test_tlr

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		repeat (4) @(posedge clock_i);
		#1;
		test_reset();
		test_preload();
		test_modes();
		test_tlr();
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge clock_i);
		num_errors++;
		$display("ERROR watchdog expected done seen running");
		finish_test();
	end
endmodule : testbench
